// >>> rtl/rx_err_pkg.sv
`default_nettype none
package rx_err_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_DATA   = 8'h08;
	localparam logic [7:0] OFF_INTEN  = 8'h0C;
	localparam logic [7:0] OFF_DIV    = 8'h10;
	localparam logic [7:0] OFF_EVT    = 8'h14;
	localparam logic [7:0] OFF_EVMASK = 8'h18;
	// control register fields
	localparam int CTRL_PORT_EN = 0;
	localparam int CTRL_CONTINUOUS_RX_ENABLE    = 1;
	localparam int CTRL_NINE    = 2;
	localparam int CTRL_ADDR    = 3;
	// status register fields
	localparam int ST_NINTH   = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_FRAME   = 2;
	localparam int ST_PENDING = 3;
	localparam int ST_COUNT   = 4;
	// interrupt enable fields
	localparam int IE_RX   = 0;
	localparam int IE_PERI = 1;
	localparam int IE_GLOB = 2;
	// event fields: 0 framing error seen, 1 overrun
	localparam int EV_FRAME = 0;
	localparam int EV_OVR   = 1;
	// reset values, fifo depth and data width
	localparam logic [3:0]  CTRL_RST  = 4'h0;
	localparam logic [2:0]  INTEN_RST = 3'h0;
	localparam logic [15:0] DIV_RST   = 16'h0010;
	localparam logic [1:0]  EVT_RST   = 2'h0;
	localparam int          FIFO_DEPTH = 2;
	localparam int          DATA_BITS  = 9;

	// one received character with its flags
	typedef struct packed {
		logic       frame_error_flag;
		logic [8:0] data;
	} rx_char_t;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_t;
endpackage
`default_nettype wire

// >>> rtl/async_serial_receiver_errors.sv
// Summary of operation
// - pending flag is high while enabled and fifo holds an unread character
// - pending flag is read-only; writes have no effect on it
// - rx interrupt needs rx, peripheral and global enables all set
// - each fifo character carries its own framing error bit
// - status shows top character framing flag; data read pops fifo
// - framing errors never stop reception, need no clear, raise no rx interrupt
// - port enable low resets receiver and framing status; continuous_rx_enable low does not
// - fifo holds two; third complete character sets overrun
// - during overrun fifo stays readable and new characters are dropped
// - overrun clears when continuous_rx_enable or port enable is cleared
// - nine-bit select shifts nine data bits per character
// - ninth bit of top character in status, low eight in data
// - address detect enable turns on address mode, needs nine-bit select
// - in address mode only characters with ninth bit one enter fifo
// - all-errored fifo keeps framing status set across reads
`default_nettype none
module async_serial_receiver_errors
	import rx_err_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_line,
	output logic             irq
);
	// control and configuration
	logic [3:0]  ctrl_ff;
	logic [3:0]  nxt_ctrl;
	logic [2:0]  inten_ff;
	logic [2:0]  nxt_inten;
	logic [15:0] div_ff;
	logic [15:0] nxt_div;
	logic [1:0]  evt_ff;
	logic [1:0]  nxt_evt;
	logic [1:0]  evmask_ff;
	logic [1:0]  nxt_evmask;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;

	// receiver datapath
	rx_state_t   state_ff;
	rx_state_t   nxt_state;
	logic [15:0] tick_ff;
	logic [15:0] nxt_tick;
	logic [3:0]  bit_ff;
	logic [3:0]  nxt_bit;
	logic [8:0]  shift_ff;
	logic [8:0]  nxt_shift;
	logic        overrun_ff;
	logic        nxt_overrun;

	// two entry fifo
	rx_char_t    fifo_ff [FIFO_DEPTH];
	rx_char_t    nxt_fifo [FIFO_DEPTH];
	logic [1:0]  count_ff;
	logic [1:0]  nxt_count;

	wire port_en   = ctrl_ff[CTRL_PORT_EN];
	wire continuous_rx_enable      = ctrl_ff[CTRL_CONTINUOUS_RX_ENABLE];
	wire nine_sel  = ctrl_ff[CTRL_NINE];
	wire addr_mode = ctrl_ff[CTRL_ADDR] & nine_sel;
	wire rx_on     = port_en & continuous_rx_enable;

	// bus decode: zero wait states, unmapped addresses read zero with an error
	wire bus_acc   = psel & penable;
	wire wr_acc    = bus_acc & pwrite;
	wire rd_acc    = bus_acc & ~pwrite;
	wire hit_ctrl  = paddr == OFF_CTRL;
	wire hit_stat  = paddr == OFF_STATUS;
	wire hit_data  = paddr == OFF_DATA;
	wire hit_inten = paddr == OFF_INTEN;
	wire hit_div   = paddr == OFF_DIV;
	wire hit_evt   = paddr == OFF_EVT;
	wire hit_mask  = paddr == OFF_EVMASK;
	wire mapped    = hit_ctrl | hit_stat | hit_data | hit_inten | hit_div | hit_evt | hit_mask;

	assign pready  = 1'b1;
	assign pslverr = bus_acc & ~mapped;
	assign prdata  = prdata_ff;

	// true while the fifo holds at least one unread character
	function automatic logic fifo_busy(input logic [1:0] cnt);
		fifo_busy = cnt != 2'd0;
	endfunction

	// a data read pops only if the fifo held a character when the word was loaded in
	// setup; otherwise a character landing mid-read would be popped without being seen
	logic pop_ok_ff;
	logic nxt_pop_ok;
	wire  rd_setup = psel & ~penable & ~pwrite;
	assign nxt_pop_ok = rd_setup & hit_data & fifo_busy(count_ff);
	wire pop = rd_acc & hit_data & pop_ok_ff;

	// continuous_rx_enable low drops the overrun, port enable low also resets receiver
	wire new_ctrl_continuous_rx_enable = pwdata[CTRL_CONTINUOUS_RX_ENABLE];
	wire new_ctrl_port = pwdata[CTRL_PORT_EN];

	rx_char_t top;
	assign top = fifo_ff[0];

	// pending flag follows occupancy while port and receive are enabled, never written
	wire pending = rx_on & fifo_busy(count_ff);

	// baud timing: half-bit point found from the divider
	wire [15:0] half_div = {1'b0, div_ff[15:1]};
	wire        tick_end = tick_ff == 16'h0000;
	wire [3:0]  nbits    = nine_sel ? 4'd9 : 4'd8;

	// character completes at the stop sample point
	logic       char_done;
	logic       stop_bad;
	logic [8:0] char_data;
	assign char_done = (state_ff == ST_STOP) & tick_end;
	assign stop_bad  = ~rx_line;
	assign char_data = nine_sel ? shift_ff : {1'b0, shift_ff[8:1]};

	// address filter: only ninth-bit-one characters pass in address mode
	wire keep = ~addr_mode | char_data[8];
	wire push_req = char_done & keep & rx_on;

	// receiver state machine
	always_comb
	begin
		nxt_state = state_ff;
		nxt_tick  = tick_end ? 16'h0000 : tick_ff - 16'h0001;
		nxt_bit   = bit_ff;
		nxt_shift = shift_ff;
		unique case (state_ff)
			ST_IDLE:
			begin
				if (rx_on && !rx_line)
				begin
					nxt_state = ST_START;
					nxt_tick  = half_div;
				end
			end
			ST_START:
			begin
				if (tick_end)
				begin
					// false start glitch returns to idle
					nxt_state = rx_line ? ST_IDLE : ST_DATA;
					nxt_tick  = div_ff;
					nxt_bit   = 4'd0;
				end
			end
			ST_DATA:
			begin
				if (tick_end)
				begin
					nxt_shift = {rx_line, shift_ff[8:1]};
					nxt_bit   = bit_ff + 4'd1;
					nxt_tick  = div_ff;
					if (bit_ff + 4'd1 == nbits)
						nxt_state = ST_STOP;
				end
			end
			ST_STOP:
			begin
				// a bad stop bit is kept and reception goes on
				if (tick_end)
					nxt_state = ST_IDLE;
			end
			default:
				nxt_state = ST_IDLE;
		endcase
		if (!rx_on)
			nxt_state = ST_IDLE;
	end

	// fifo push and pop; overrun blocks pushes until cleared
	always_comb
	begin
		nxt_fifo    = fifo_ff;
		nxt_count   = count_ff;
		nxt_overrun = overrun_ff;
		if (pop)
		begin
			nxt_fifo[0] = fifo_ff[1];
			nxt_count   = count_ff - 2'd1;
		end
		if (push_req && !overrun_ff)
		begin
			if (count_ff == 2'd2 && !pop)
				nxt_overrun = 1'b1;
			else
				nxt_fifo[nxt_count[0]] = '{frame_error_flag: stop_bad, data: char_data};
			if (!(count_ff == 2'd2 && !pop))
				nxt_count = nxt_count + 2'd1;
		end
		if (wr_acc && hit_ctrl && (!new_ctrl_continuous_rx_enable || !new_ctrl_port))
			nxt_overrun = 1'b0;
		if (wr_acc && hit_ctrl && !new_ctrl_port)
		begin
			nxt_count = 2'd0;
			nxt_fifo[0].frame_error_flag = 1'b0;
		end
	end

	// status word seen by software
	wire [31:0] status_word = {26'd0, count_ff,
		pending, fifo_busy(count_ff) & top.frame_error_flag, overrun_ff, top.data[8]};

	// event flags: set wins over write-one clear
	wire [1:0] ev_set = {push_req & ~overrun_ff & (count_ff == 2'd2) & ~pop,
		push_req & ~overrun_ff & stop_bad};

	always_comb
	begin
		nxt_ctrl   = ctrl_ff;
		nxt_inten  = inten_ff;
		nxt_div    = div_ff;
		nxt_evmask = evmask_ff;
		nxt_evt    = evt_ff;
		if (wr_acc && hit_ctrl)
			nxt_ctrl = pwdata[3:0];
		if (wr_acc && hit_inten)
			nxt_inten = pwdata[2:0];
		if (wr_acc && hit_div)
			nxt_div = pwdata[15:0];
		if (wr_acc && hit_mask)
			nxt_evmask = pwdata[1:0];
		if (wr_acc && hit_evt)
			nxt_evt = evt_ff & ~pwdata[1:0];
		nxt_evt = nxt_evt | ev_set;
	end

	// read mux; the data read returns the character about to be popped
	logic [31:0] rd_word;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (hit_ctrl)
			rd_word = {28'd0, ctrl_ff};
		else if (hit_stat)
			rd_word = status_word;
		else if (hit_data)
			rd_word = {24'd0, top.data[7:0]};
		else if (hit_inten)
			rd_word = {29'd0, inten_ff};
		else if (hit_div)
			rd_word = {16'd0, div_ff};
		else if (hit_evt)
			rd_word = {30'd0, evt_ff};
		else if (hit_mask)
			rd_word = {30'd0, evmask_ff};
	end

	// read data is loaded at the end of setup so it already stands in the access
	// cycle, where the master takes it; held through the access, zero otherwise
	always_comb
	begin
		nxt_prdata = 32'h0000_0000;
		if (rd_setup)
			nxt_prdata = rd_word;
		else if (rd_acc)
			nxt_prdata = prdata_ff;
	end

	// rx interrupt needs all three enables; of the events only overrun may reach irq,
	// since a framing error on its own must never interrupt
	wire rx_irq  = pending & inten_ff[IE_RX] & inten_ff[IE_PERI] & inten_ff[IE_GLOB];
	wire evt_irq = evt_ff[EV_OVR] & evmask_ff[EV_OVR];
	assign irq = rx_irq | evt_irq;

	// bit timing and shift path
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ST_IDLE;
			tick_ff  <= 16'h0000;
			bit_ff   <= 4'h0;
			shift_ff <= 9'h000;
		end
		else
		begin
			state_ff <= nxt_state;
			tick_ff  <= nxt_tick;
			bit_ff   <= nxt_bit;
			shift_ff <= nxt_shift;
		end
	end

	// overrun stays until continuous_rx_enable or port enable is written low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			overrun_ff <= 1'b0;
		else
			overrun_ff <= nxt_overrun;
	end

	// fifo storage and occupancy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_ff   <= 2'd0;
			fifo_ff[0] <= '0;
			fifo_ff[1] <= '0;
		end
		else
		begin
			count_ff <= nxt_count;
			fifo_ff  <= nxt_fifo;
		end
	end

	// data read armed in setup, used in the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pop_ok_ff <= 1'b0;
		else
			pop_ok_ff <= nxt_pop_ok;
	end

	// control and configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff  <= CTRL_RST;
			inten_ff <= INTEN_RST;
			div_ff   <= DIV_RST;
		end
		else
		begin
			ctrl_ff  <= nxt_ctrl;
			inten_ff <= nxt_inten;
			div_ff   <= nxt_div;
		end
	end

	// sticky events and their mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			evt_ff    <= EVT_RST;
			evmask_ff <= EVT_RST;
		end
		else
		begin
			evt_ff    <= nxt_evt;
			evmask_ff <= nxt_evmask;
		end
	end

	// read data register; a flop keeps prdata glitch free for the master
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= 32'h0000_0000;
		else
			prdata_ff <= nxt_prdata;
	end
endmodule
`default_nettype wire

// >>> tb/rx_err_asserts.sv
`default_nettype none
module rx_err_asserts
	import rx_err_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       acc;
	logic       wr;
	logic       rs;
	logic [3:0] ctl_ff;
	logic [2:0] ie_ff;
	logic [1:0] msk_ff;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completed access and write strobes
	assign acc = psel && penable && pready;
	assign wr  = acc && pwrite;
	// status word stands in the access cycle, loaded from the settings then in force
	assign rs  = acc && !pwrite && paddr == OFF_STATUS;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			{ctl_ff, ie_ff, msk_ff} <= '0;
		end
		else
		begin
			if (wr && paddr == OFF_CTRL)
				ctl_ff <= pwdata[3:0];
			if (wr && paddr == OFF_INTEN)
				ie_ff <= pwdata[2:0];
			if (wr && paddr == OFF_EVMASK)
				msk_ff <= pwdata[1:0];
		end
	pend_state_a: assert property
		(rs |-> prdata[ST_PENDING] == (ctl_ff[1:0] == 2'b11 && prdata[5:4] != 2'b00))
		else $error("pending flag wrong");
	fifo_depth_a: assert property
		(rs |-> prdata[5:4] <= 2'b10)
		else $error("fifo count above two");
	port_off_a: assert property
		(rs && !ctl_ff[0] |-> prdata[5:1] == 5'h00)
		else $error("status not cleared by port disable");
	ovr_cleared_a: assert property
		(rs && !ctl_ff[1] |-> !prdata[ST_OVERRUN])
		else $error("overrun kept without receive enable");
	irq_gate_a: assert property
		(ie_ff != 3'h7 && msk_ff == 2'h0 |-> !irq)
		else $error("interrupt without all enables");
	unmapped_err_a: assert property
		($rose(penable) && psel && paddr > OFF_EVMASK |-> pslverr)
		else $error("no error on unmapped access");
	mapped_ok_a: assert property
		(acc && paddr <= OFF_EVMASK && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("error on mapped access");
	zero_wait_a: assert property
		(psel && !penable |=> pready [*2])
		else $error("wait state inserted");
	cover property (rs && prdata[ST_OVERRUN]);
	cover property (irq);
	cover property (acc && pslverr);
endmodule
`default_nettype wire

// >>> tb/ser_tx.sv
`default_nettype none
module ser_tx
(
	input  wire logic pclk,
	output var  logic rx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BT = 17; // divider reset value plus one
	initial rx_line = 1'b1;
	// lsb first; a bad stop is low from its start to just past its sample point, so a false start follows that the glitch check rejects
	task automatic send(input logic [8:0] dt, input logic nine, input logic fe);
		logic [10:0] f;
		int          n;
		f = nine ? {1'b1, dt, 1'b0} : {2'b11, dt[7:0], 1'b0};
		n = nine ? 11 : 10;
		for (int i = 0; i < n; i++)
		begin
			rx_line <= f[i] & !(fe && i == n - 1);
			repeat (12) @(posedge pclk);
			rx_line <= f[i];
			repeat (BT - 12) @(posedge pclk);
		end
		repeat (2 * BT) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_async_serial_receiver_errors.sv
`default_nettype none
module tb_async_serial_receiver_errors
	import rx_err_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, d;
	logic        pready, pslverr, irq;
	wire logic   rx_line;
	int          n_errors = 0, num_checks = 0, cyc = 0, seed = 7794;
	logic [9:0]  q[$];
	logic [9:0]  v;
	logic [3:0]  c = 0;
	logic        ovr = 0;
	always #4 pclk = ~pclk;
	async_serial_receiver_errors i_async_serial_receiver_errors (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_line, .irq);
	ser_tx i_ser_tx (.pclk, .rx_line);
	task close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard; a full run needs well under this
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			close_out;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
		num_checks++;
		if ((g & m) !== (e & m))
		begin
			n_errors++;
			$display("Error %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// read data is taken at the access edge; one more edge lets register effects settle
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		slv = pslverr;
		d = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task setc(input logic [3:0] x);
		xfer(1, OFF_CTRL, {28'h0, x});
		c = x;
		if (!x[0])
			q.delete();
		if (!x[0] || !x[1])
			ovr = 0;
	endtask
	// the model only takes a character the receiver would accept
	task send(input logic [8:0] dt, input logic fe);
		i_ser_tx.send(dt, c[2], fe);
		if (!c[2])
			dt[8] = 1'b0;
		if (c[1:0] == 2'b11 && !ovr && !(c[3] && c[2] && !dt[8]))
			if (q.size() < 2)
				q.push_back({fe, dt});
			else
				ovr = 1'b1;
	endtask
	task st;
		int n;
		n = q.size();
		v = n > 0 ? q[0] : 10'h0;
		xfer(0, OFF_STATUS, 0);
		chk(d, {26'h0, 2'(n), c[1:0] == 2'b11 && n > 0, v[9], ovr, v[8]},
			n > 0 ? 32'h3f : (c[0] ? 32'h3a : 32'h3e));
	endtask
	task pop;
		st;
		xfer(0, OFF_DATA, 0);
		v = q.pop_front();
		chk(d, {24'h0, v[7:0]}, 32'hff);
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		xfer(0, OFF_CTRL, 0);
		chk(d, 32'h0, 32'hf);
		xfer(0, OFF_DIV, 0);
		chk(d, 32'h10, 32'hffff);
		xfer(0, 8'h1c, 0);
		chk({31'h0, slv}, 32'h1, 32'h1);
		setc(4'h7);
		for (int i = 0; i < 3; i++)
			send(9'($random(seed)), i == 1);
		chk({31'h0, irq}, 32'h0, 32'h1);
		xfer(1, OFF_STATUS, 32'hffff_ffff);
		st;
		xfer(0, OFF_EVT, 0);
		chk(d, 32'h3, 32'h3);
		xfer(1, OFF_INTEN, 32'h7);
		chk({31'h0, irq}, 32'h1, 32'h1);
		xfer(1, OFF_INTEN, 32'h3);
		chk({31'h0, irq}, 32'h0, 32'h1);
		xfer(1, OFF_EVMASK, 32'h3);
		chk({31'h0, irq}, 32'h1, 32'h1);
		xfer(1, OFF_EVT, 32'h3);
		chk({31'h0, irq}, 32'h0, 32'h1);
		xfer(1, OFF_EVMASK, 32'h0);
		pop;
		setc(4'h5);
		st;
		setc(4'h0);
		st;
		setc(4'hf);
		send({1'b0, 8'($random(seed))}, 0);
		send({1'b1, 8'($random(seed))}, 0);
		st;
		setc(4'h7);
		send({1'b0, 8'($random(seed))}, 0);
		pop;
		pop;
		setc(4'h3);
		send(9'($random(seed)), 1);
		send(9'($random(seed)), 1);
		pop;
		pop;
		st;
		close_out;
	end
endmodule
bind async_serial_receiver_errors rx_err_asserts i_rx_err_asserts (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
`default_nettype wire
